/* hdl/ddss_pkg.sv */
package ddss_pkg;
  // ---------------------------------------------------------------
  // Tag codes
  // ---------------------------------------------------------------
  localparam logic [2:0] TAG_NONE   = 3'h0;
  localparam logic [2:0] TAG_CYL_LO = 3'h1;
  localparam logic [2:0] TAG_CYL_HI = 3'h2;
  localparam logic [2:0] TAG_CTL    = 3'h3;
  localparam logic [2:0] TAG_STATUS = 3'h4;
  localparam logic [2:0] TAG_SENSE1 = 3'h5;
  localparam logic [2:0] TAG_SENSE2 = 3'h6;
  localparam logic [2:0] TAG_SENSE3 = 3'h7;
  // ---------------------------------------------------------------
  // Control byte fields (tag 011) and address byte (tag 010)
  // ---------------------------------------------------------------
  localparam int CTL_RECAL  = 7;
  localparam int CTL_RSTERR = 6;
  localparam int CTL_MHS    = 5;
  localparam int CTL_FHS    = 4;
  localparam int HI_CYL     = 0;
  localparam int HI_HEAD_LO = 3;
  localparam int HI_HEAD_HI = 7;
  // ---------------------------------------------------------------
  // Status byte bits; bit 0 of each byte is its least significant bit
  // ---------------------------------------------------------------
  localparam int ST_FHNS  = 7;
  localparam int ST_BRAKE = 6;
  localparam int ST_TNA   = 5;
  localparam int ST_CMDE  = 4;
  localparam int ST_UNSF  = 3;
  localparam int ST_SINC  = 2;
  localparam int ST_HOME  = 1;
  localparam int ST_NRDY  = 0;
  // ---------------------------------------------------------------
  // Geometry and reset values
  // ---------------------------------------------------------------
  localparam logic [8:0] CYL_MAX   = 9'h167;
  localparam logic [8:0] CYL_HOME  = 9'h000;
  localparam logic [4:0] HEAD_HOME = 5'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PES_LIM   = 8'h19;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_NS       = 4;
  localparam longint NS_PER_MS    = 1000000;
  localparam longint OVL_NS       = 10;
  localparam longint SEEK_TMO_MS  = 1700;
  localparam longint BRAKE_MS     = 5000;
  localparam int     OVL_CYC      = int'((OVL_NS + CLK_NS - 1) / CLK_NS);
  localparam longint SEEK_TMO_CYC = SEEK_TMO_MS * NS_PER_MS / CLK_NS;
  localparam longint BRAKE_CYC    = BRAKE_MS * NS_PER_MS / CLK_NS;
  localparam int     SAMPLE_CNT   = 256;
  localparam int     IDX_TMO_CYC  = 1048576;
endpackage

/* hdl/ddss_pulse_det.sv */
`timescale 1ns/1ns
module ddss_pulse_det #(
  parameter int W = 8,
  parameter int N = ddss_pkg::SAMPLE_CNT
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         reset_n_i,
  // Sense bits in, pulsing bits out
  input  wire logic [W-1:0] sense_i,
  output logic      [W-1:0] pulse_o
);
  localparam int CW = $clog2(N);

  logic [CW-1:0] cnt;
  logic [W-1:0]  ref_val;
  logic [W-1:0]  chg;

  // Window restarts from the current value so one glitch is not counted twice
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt     <= '0;
      ref_val <= '0;
      chg     <= '0;
      pulse_o <= '0;
    end else begin
      cnt <= cnt + 1'b1;
      if (cnt == CW'(N - 1)) begin
        pulse_o <= chg | (sense_i ^ ref_val);
        chg     <= '0;
        ref_val <= sense_i;
      end else begin
        chg <= chg | (sense_i ^ ref_val);
      end
    end
  end
endmodule

/* hdl/ddss_status_sense.sv */
`timescale 1ns/1ns
// How it works
// - Tags 100/101/110 return status, sense bytes
// - Fixed-head-not-selected set on completions, cleared by fixed head select
// - Cylinder over 359 flags unavailable, no move
// - Parity or bad tag sets command error
// - Keep parity; recheck address before writing
// - Unsafe: flag, interrupt, kill write, deselect
// - Listed write/read hazards set unsafe
// - Reset error clears unsafe unless a hazard is still present
// - Seek incomplete while busy or not ready
// - Home only after recalibrate or power-up
// - Next tag 001 clears home
// - Not-ready sources set it; recalibrate clears
// - Brake reported; power down within 5 s
// - Bad tag code or parity sets sense flag
// - Drive bits encode voice coil state
// - On track within ten percent of center
// - Velocity error sticky until reset error
// - Index/sector missing flag
// - Pulsing bit marks changing sense bit
module ddss_status_sense #(
  parameter int unsigned SEEK_TMO_CYC = 32'(ddss_pkg::SEEK_TMO_CYC),
  parameter int unsigned BRAKE_CYC    = 32'(ddss_pkg::BRAKE_CYC),
  parameter int unsigned IDX_TMO_CYC  = 32'(ddss_pkg::IDX_TMO_CYC)
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  // Tag lines and control bus from the adapter
  input  wire logic       tag_stb_i,
  input  wire logic [2:0] tag_i,
  input  wire logic       tag_par_i,
  input  wire logic [7:0] ctl_i,
  input  wire logic       ctl_par_i,
  // Answers to the adapter
  output logic      [7:0] sense_bus_o,
  output logic            sense_par_o,
  output logic      [7:0] pulse_bus_o,
  output logic            pulse_par_o,
  output logic            sense_vld_o,
  output logic            attn_o,
  // Actuator and heads
  output logic            seek_start_o,
  output logic            recal_start_o,
  output logic            mhs_start_o,
  output logic      [8:0] target_cyl_o,
  output logic      [4:0] head_o,
  output logic            heads_sel_o,
  output logic            write_en_o,
  output logic            power_down_o,
  input  wire logic       access_done_i,
  input  wire logic       power_up_done_i,
  // Read/write hazards
  input  wire logic       write_i,
  input  wire logic       read_i,
  input  wire logic       multi_sel_i,
  input  wire logic       sector_pulse_i,
  input  wire logic       index_i,
  input  wire logic       write_cur_det_i,
  input  wire logic       no_write_trans_i,
  input  wire logic       head_short_i,
  // Drive condition
  input  wire logic       servo_unsafe_i,
  input  wire logic       invalid_move_i,
  input  wire logic       plo_sync_i,
  input  wire logic       disk_moving_i,
  input  wire logic       osc_running_i,
  input  wire logic       power_ok_i,
  input  wire logic       brake_i,
  input  wire logic       vel_err_i,
  input  wire logic [7:0] pes_mag_i,
  input  wire logic       linear_i,
  input  wire logic       drive_out_i,
  input  wire logic       drive_in_i,
  input  wire logic [7:0] sense2_i
);
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OP_IDLE, OP_SEEK, OP_RECAL, OP_MHS} ddss_op_t;

  function automatic logic odd_ok(input logic [7:0] d, input logic p);
    odd_ok = ^{d, p};
  endfunction

  ddss_op_t   op;
  logic       tag_good, bad_tag, ctl_good, cmd_tag, cmd_bad, cmd_go;
  logic       rst_err, cyl_go, recal_go, mhs_go, fhs_go, sense_tag;
  logic [8:0] new_cyl;
  logic       cyl_bad;
  logic       cyl_hi, unsafe;

  assign tag_good  = tag_stb_i && odd_ok({5'h00, tag_i}, tag_par_i)
                     && (tag_i != ddss_pkg::TAG_NONE);
  assign bad_tag   = tag_stb_i && !tag_good;
  assign ctl_good  = odd_ok(ctl_i, ctl_par_i);
  assign cmd_tag   = tag_good && (tag_i < ddss_pkg::TAG_STATUS);
  assign cmd_bad   = cmd_tag && !ctl_good;
  // Only sense and reset error get through while unsafe
  assign cmd_go    = cmd_tag && ctl_good && !unsafe;
  assign rst_err   = cmd_tag && ctl_good && (tag_i == ddss_pkg::TAG_CTL)
                     && ctl_i[ddss_pkg::CTL_RSTERR];
  assign cyl_go    = cmd_go && (tag_i == ddss_pkg::TAG_CYL_LO);
  assign recal_go  = cmd_go && (tag_i == ddss_pkg::TAG_CTL) && ctl_i[ddss_pkg::CTL_RECAL];
  assign mhs_go    = cmd_go && (tag_i == ddss_pkg::TAG_CTL) && ctl_i[ddss_pkg::CTL_MHS];
  assign fhs_go    = cmd_go && (tag_i == ddss_pkg::TAG_CTL) && ctl_i[ddss_pkg::CTL_FHS];
  assign sense_tag = tag_good && (tag_i >= ddss_pkg::TAG_STATUS);
  assign new_cyl   = {cyl_hi, ctl_i};
  assign cyl_bad   = new_cyl > ddss_pkg::CYL_MAX;

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  logic fhns, track_na, cmd_err, home, nrdy, tag_perr, vel_err;
  logic tag_lock, addr_ok, mh_sel, out_dir, idx_miss, seek_tmo;
  logic done_seek, done_recal, done_mhs, unsafe_src, nr_src, on_track;
  logic [8:0] cur_cyl;
  logic [7:0] status_byte, sense1_byte, pulse1, pulse2;

  assign done_seek  = access_done_i && (op == OP_SEEK);
  assign done_recal = (access_done_i && (op == OP_RECAL)) || power_up_done_i;
  assign done_mhs   = access_done_i && (op == OP_MHS);
  assign on_track   = pes_mag_i <= ddss_pkg::PES_LIM;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fhns <= 1'b0;
    end else if (done_seek || done_recal || done_mhs) begin
      fhns <= 1'b1;
    end else if (fhs_go) begin
      fhns <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      track_na <= 1'b0;
      addr_ok  <= 1'b0;
    end else begin
      if (cyl_go) begin
        track_na <= cyl_bad;
      end
      // Writes wait for a fresh checked address after a command error
      if (cmd_bad || bad_tag) begin
        addr_ok <= 1'b0;
      end else if (cyl_go && !cyl_bad) begin
        addr_ok <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_err  <= 1'b0;
      tag_perr <= 1'b0;
      tag_lock <= 1'b0;
      vel_err  <= 1'b0;
    end else begin
      if (bad_tag || cmd_bad) begin
        cmd_err <= 1'b1;
      end else if (rst_err) begin
        cmd_err <= 1'b0;
      end
      if (bad_tag) begin
        tag_perr <= 1'b1;
        tag_lock <= 1'b1;
      end else if (rst_err) begin
        tag_perr <= 1'b0;
        tag_lock <= 1'b0;
      end
      if (vel_err_i) begin
        vel_err <= 1'b1;
      end else if (rst_err) begin
        vel_err <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data unsafe
  // ---------------------------------------------------------------
  logic [3:0] ovl_cnt;
  logic       ovl;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovl_cnt <= '0;
    end else if (write_i && read_i) begin
      if (!ovl) begin
        ovl_cnt <= ovl_cnt + 1'b1;
      end
    end else begin
      ovl_cnt <= '0;
    end
  end
  assign ovl = write_i && read_i && (ovl_cnt >= 4'(ddss_pkg::OVL_CYC - 1));

  assign unsafe_src = ((write_i || read_i) && multi_sel_i) || ovl
                      || (write_i && (nrdy || !on_track || servo_unsafe_i))
                      || (write_i && mh_sel && sector_pulse_i)
                      || (write_i && (no_write_trans_i || head_short_i))
                      || (!write_i && write_cur_det_i);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unsafe <= 1'b0;
    end else if (unsafe_src) begin
      unsafe <= 1'b1;
    end else if (rst_err) begin
      unsafe <= 1'b0;
    end
  end

  // Write current is gated with no register in the path
  assign write_en_o = write_i && heads_sel_o && !unsafe && !unsafe_src && addr_ok;

  // ---------------------------------------------------------------
  // Access sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op            <= OP_IDLE;
      seek_start_o  <= 1'b0;
      recal_start_o <= 1'b0;
      mhs_start_o   <= 1'b0;
      target_cyl_o  <= ddss_pkg::CYL_HOME;
      cur_cyl       <= ddss_pkg::CYL_HOME;
      out_dir       <= 1'b0;
    end else begin
      seek_start_o  <= 1'b0;
      recal_start_o <= 1'b0;
      mhs_start_o   <= 1'b0;
      case (op)
        OP_IDLE: begin
          if (recal_go) begin
            op            <= OP_RECAL;
            recal_start_o <= 1'b1;
            target_cyl_o  <= ddss_pkg::CYL_HOME;
          end else if (cyl_go && !cyl_bad) begin
            op           <= OP_SEEK;
            seek_start_o <= 1'b1;
            target_cyl_o <= new_cyl;
            out_dir      <= new_cyl > cur_cyl;
          end else if (mhs_go) begin
            op          <= OP_MHS;
            mhs_start_o <= 1'b1;
          end
        end
        OP_SEEK, OP_MHS: begin
          if (recal_go) begin
            op            <= OP_RECAL;
            recal_start_o <= 1'b1;
            target_cyl_o  <= ddss_pkg::CYL_HOME;
          end else if (access_done_i) begin
            op      <= OP_IDLE;
            cur_cyl <= target_cyl_o;
          end
        end
        OP_RECAL: begin
          if (access_done_i) begin
            op      <= OP_IDLE;
            cur_cyl <= ddss_pkg::CYL_HOME;
          end
        end
        default: op <= OP_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyl_hi      <= 1'b0;
      head_o      <= ddss_pkg::HEAD_HOME;
      heads_sel_o <= 1'b0;
      mh_sel      <= 1'b0;
    end else begin
      if (cmd_go && (tag_i == ddss_pkg::TAG_CYL_HI)) begin
        cyl_hi <= ctl_i[ddss_pkg::HI_CYL];
        head_o <= ctl_i[ddss_pkg::HI_HEAD_HI:ddss_pkg::HI_HEAD_LO];
      end else if (done_recal) begin
        head_o <= ddss_pkg::HEAD_HOME;
      end
      if (unsafe_src) begin
        heads_sel_o <= 1'b0;
      end else if (done_recal || mhs_go || fhs_go) begin
        heads_sel_o <= 1'b1;
      end
      if (done_recal || mhs_go) begin
        mh_sel <= 1'b1;
      end else if (fhs_go) begin
        mh_sel <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      home <= 1'b0;
    end else if (done_recal) begin
      home <= 1'b1;
    end else if (tag_good && (tag_i == ddss_pkg::TAG_CYL_LO)) begin
      home <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Not ready, timers
  // ---------------------------------------------------------------
  logic [31:0] seek_cnt, brake_cnt, idx_cnt;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seek_cnt <= '0;
    end else if (op == OP_SEEK || op == OP_RECAL) begin
      if (!seek_tmo) begin
        seek_cnt <= seek_cnt + 1'b1;
      end
    end else begin
      seek_cnt <= '0;
    end
  end
  assign seek_tmo = seek_cnt >= SEEK_TMO_CYC - 1;

  assign nr_src = seek_tmo || invalid_move_i || !plo_sync_i || !disk_moving_i
                  || !osc_running_i || !power_ok_i || servo_unsafe_i;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nrdy <= 1'b0;
    end else if (nr_src) begin
      nrdy <= 1'b1;
    end else if (done_recal) begin
      nrdy <= 1'b0;
    end
  end

  // Power down is held until reset; the brake cannot be undone here
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      brake_cnt    <= '0;
      power_down_o <= 1'b0;
    end else if (brake_i) begin
      if (brake_cnt >= BRAKE_CYC - 1) begin
        power_down_o <= 1'b1;
      end else begin
        brake_cnt <= brake_cnt + 1'b1;
      end
    end else begin
      brake_cnt <= '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_cnt  <= '0;
      idx_miss <= 1'b0;
    end else if (index_i || sector_pulse_i) begin
      idx_cnt  <= '0;
      idx_miss <= 1'b0;
    end else if (idx_cnt >= IDX_TMO_CYC - 1) begin
      idx_miss <= 1'b1;
    end else begin
      idx_cnt <= idx_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bytes and answers
  // ---------------------------------------------------------------
  always_comb begin
    status_byte                    = ddss_pkg::BYTE_ZERO;
    status_byte[ddss_pkg::ST_FHNS]  = fhns;
    status_byte[ddss_pkg::ST_BRAKE] = brake_i;
    status_byte[ddss_pkg::ST_TNA]   = track_na;
    status_byte[ddss_pkg::ST_CMDE]  = cmd_err;
    status_byte[ddss_pkg::ST_UNSF]  = unsafe;
    status_byte[ddss_pkg::ST_SINC]  = (op != OP_IDLE) || nrdy;
    status_byte[ddss_pkg::ST_HOME]  = home;
    status_byte[ddss_pkg::ST_NRDY]  = nrdy;
  end

  assign sense1_byte = {on_track, linear_i, idx_miss, out_dir,
                        !drive_out_i, !drive_in_i, tag_perr, vel_err};

  ddss_pulse_det #(.W(8), .N(ddss_pkg::SAMPLE_CNT)) u_pulse1 (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .sense_i   (sense1_byte),
    .pulse_o   (pulse1)
  );

  ddss_pulse_det #(.W(8), .N(ddss_pkg::SAMPLE_CNT)) u_pulse2 (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .sense_i   (sense2_i),
    .pulse_o   (pulse2)
  );

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sense_bus_o <= ddss_pkg::BYTE_ZERO;
      pulse_bus_o <= ddss_pkg::BYTE_ZERO;
      sense_vld_o <= 1'b0;
    end else begin
      sense_vld_o <= sense_tag;
      if (sense_tag) begin
        case (tag_i)
          ddss_pkg::TAG_STATUS: begin
            sense_bus_o <= status_byte;
            pulse_bus_o <= ddss_pkg::BYTE_ZERO;
          end
          ddss_pkg::TAG_SENSE1: begin
            sense_bus_o <= sense1_byte;
            pulse_bus_o <= pulse1;
          end
          ddss_pkg::TAG_SENSE2: begin
            sense_bus_o <= sense2_i;
            pulse_bus_o <= pulse2;
          end
          default: begin
            sense_bus_o <= ddss_pkg::BYTE_ZERO;
            pulse_bus_o <= ddss_pkg::BYTE_ZERO;
          end
        endcase
      end
    end
  end

  // Parity stays correct whatever the error state
  assign sense_par_o = ~^sense_bus_o;
  assign pulse_par_o = ~^pulse_bus_o;

  // A tag error keeps the interrupt through every sense until reset error
  logic irq_ev;
  assign irq_ev = (cyl_go && cyl_bad) || bad_tag || cmd_bad || (unsafe_src && !unsafe)
                  || done_recal || (nr_src && !nrdy);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      attn_o <= 1'b0;
    end else if (irq_ev) begin
      attn_o <= 1'b1;
    end else if (sense_tag && !tag_lock) begin
      attn_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_bad_tag;
    tag_stb_i && !tag_good;
  endsequence
  sequence s_bad_cyl;
    cyl_go && cyl_bad;
  endsequence

  property p_status_ans;
    tag_good && tag_i == ddss_pkg::TAG_STATUS |=>
      sense_vld_o && sense_bus_o == $past(status_byte);
  endproperty
  a_status_ans: assert property (p_status_ans) else $error("status byte wrong");

  property p_fhns_clr;
    fhs_go && !access_done_i && !power_up_done_i |=> !fhns;
  endproperty
  a_fhns_clr: assert property (p_fhns_clr) else $error("fixed head flag stuck");

  property p_track_na;
    s_bad_cyl |=> track_na && attn_o && !seek_start_o;
  endproperty
  a_track_na: assert property (p_track_na) else $error("bad cylinder not flagged");

  property p_cmd_err;
    s_bad_tag |=> cmd_err && tag_perr && attn_o ##1 attn_o;
  endproperty
  a_cmd_err: assert property (p_cmd_err) else $error("tag error not flagged");

  property p_unsafe;
    unsafe_src |-> !write_en_o ##1 unsafe && !heads_sel_o;
  endproperty
  a_unsafe: assert property (p_unsafe) else $error("unsafe not enforced");

  property p_rst_err;
    rst_err && !unsafe_src |=> !unsafe;
  endproperty
  a_rst_err: assert property (p_rst_err) else $error("reset error kept unsafe");

  property p_seek_inc;
    seek_start_o || recal_start_o || mhs_start_o || nrdy |-> status_byte[ddss_pkg::ST_SINC];
  endproperty
  a_seek_inc: assert property (p_seek_inc) else $error("seek incomplete missing");

  property p_home_clr;
    tag_good && tag_i == ddss_pkg::TAG_CYL_LO && !done_recal |=> !home;
  endproperty
  a_home_clr: assert property (p_home_clr) else $error("home not cleared");

  property p_nrdy;
    nr_src |=> nrdy [*2];
  endproperty
  a_nrdy: assert property (p_nrdy) else $error("not ready missed");

  property p_vel;
    vel_err_i |=> vel_err until_with rst_err;
  endproperty
  a_vel: assert property (p_vel) else $error("velocity error dropped");
endmodule

/* verif/ddss_actuator.sv */
`timescale 1ns/1ns
module ddss_actuator (
  // Clock and commands
  input  wire logic ref_clk_i,
  input  wire logic start_i,
  input  wire logic slow_i,
  // Completion pulse
  output logic      done_o
);
  // Slow mode outlasts the shortened seek timeout
  int cnt = 0;
  initial done_o = 1'b0;
  always @(posedge ref_clk_i) begin
    done_o <= start_i ? 1'b0 : (cnt == 1);
    cnt    <= start_i ? (slow_i ? 200 : 5) : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule

/* verif/ddss_status_sense_tb.sv */
`timescale 1ns/1ns
module ddss_status_sense_tb;
  logic       ref_clk_i, reset_n_i, tag_stb_i, tag_par_i, ctl_par_i, slow, done;
  logic       sv, sp, attn, ss, rs, ms, hsel, wen, pd, wr, rd, vel, brk;
  logic [2:0] tag_i;
  logic [1:0] dr;
  logic [5:0] flt;
  logic       pwr, msel, idx, wcd, pp;
  logic [7:0] ctl_i, pes, s2, sb, pb;
  logic [8:0] tcyl, cyl;
  logic [4:0] head;
  int         failures = 0, cmp_count = 0;
  ddss_status_sense #(.SEEK_TMO_CYC(50), .BRAKE_CYC(50), .IDX_TMO_CYC(20)) i_ddss_status_sense (
    .ref_clk_i, .reset_n_i, .tag_stb_i, .tag_i, .tag_par_i, .ctl_i, .ctl_par_i,
    .sense_bus_o(sb), .sense_par_o(sp), .pulse_bus_o(pb), .pulse_par_o(pp), .sense_vld_o(sv),
    .attn_o(attn), .seek_start_o(ss), .recal_start_o(rs), .mhs_start_o(ms),
    .target_cyl_o(tcyl), .head_o(head), .heads_sel_o(hsel), .write_en_o(wen),
    .power_down_o(pd), .access_done_i(done), .power_up_done_i(pwr), .write_i(wr),
    .read_i(rd), .multi_sel_i(msel), .sector_pulse_i(1'b0), .index_i(idx),
    .write_cur_det_i(wcd), .no_write_trans_i(1'b0), .head_short_i(flt[4]),
    .servo_unsafe_i(flt[5]), .invalid_move_i(flt[1]), .plo_sync_i(~flt[2]),
    .disk_moving_i(~flt[3]), .osc_running_i(~flt[0]), .power_ok_i(~flt[4]), .brake_i(brk),
    .vel_err_i(vel), .pes_mag_i(pes), .linear_i(pes[0]), .drive_out_i(dr[1]),
    .drive_in_i(dr[0]), .sense2_i(s2));
  ddss_actuator i_ddss_actuator (.ref_clk_i, .start_i(ss | rs | ms), .slow_i(slow), .done_o(done));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] s1_exp(input logic [7:0] p, input logic [1:0] d);
    return {p <= 8'h19, 1'b0, 1'b1, 1'b0, ~d[1], ~d[0], 2'b00};
  endfunction
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic tag(input logic [2:0] c, input logic [7:0] d, input logic bad = 1'b0);
    cyc(1);
    tag_stb_i = 1'b1; tag_i = c; tag_par_i = ~^c ^ bad; ctl_i = d; ctl_par_i = ~^d;
    cyc(1);
    tag_stb_i = 1'b0;
  endtask
  task automatic rd_byte(input logic [2:0] c, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    tag(c, 8'h00);
    while (sv !== 1'b1 && n < 4) begin cyc(1); n++; end
    chk("valid", sv, 1'b1);
    chk("parity", sp, ~^sb);
    chk("answer", sb & m, e);
  endtask
  task automatic seek(input logic [8:0] c);
    tag(3'h2, {5'h01, 2'b00, c[8]});
    tag(3'h1, c[7:0]);
  endtask
  task automatic bwait();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 300) begin cyc(1); n++; end
    cyc(2);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // Full run is near 1.5k cycles; generous margin
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {reset_n_i, tag_stb_i, tag_i, tag_par_i, ctl_i, ctl_par_i, slow, wr, rd, vel, brk} = '0;
    {flt, dr, pes, pwr, msel, idx, wcd} = '0;
    s2 = 8'h00;
    void'($urandom(32'h1ba5fd1a));
    cyc(12);
    reset_n_i = 1'b1;
    rd_byte(3'h4, 8'hff, 8'h00);
    tag(3'h3, 8'h80); bwait();
    chk("head", head, 5'h01);
    chk("attn", attn, 1'b1);
    rd_byte(3'h4, 8'hff, 8'h82);
    for (int i = 0; i < 8; i++) begin
      cyl = (i == 0) ? 9'h167 : (i == 1) ? 9'h000 : 9'($urandom_range(359));
      s2 = 8'($urandom);
      seek(cyl); bwait();
      chk("target", tcyl, cyl);
      rd_byte(3'h4, 8'hff, 8'h80);
      rd_byte(3'h6, 8'hff, s2);
    end
    seek(9'h168); cyc(3);
    chk("attn", attn, 1'b1);
    chk("target", tcyl, cyl);
    rd_byte(3'h4, 8'hff, 8'ha0);
    seek(9'h0a0); bwait();
    rd_byte(3'h4, 8'hff, 8'h80);
    tag(3'h4, 8'h00, 1'b1); tag(3'h0, 8'h00); cyc(3);
    chk("attn", attn, 1'b1);
    rd_byte(3'h5, 8'h02, 8'h02);
    rd_byte(3'h4, 8'hff, 8'h90);
    chk("attn", attn, 1'b1);
    tag(3'h3, 8'h40);
    rd_byte(3'h4, 8'hff, 8'h80);
    chk("attn", attn, 1'b0);
    wr = 1'b1; #1;
    chk("write", wen, 1'b0);
    wr = 1'b0; seek(9'h0a0); bwait();
    wr = 1'b1; #1;
    chk("write", wen, 1'b1);
    rd = 1'b1; cyc(4);
    chk("write", wen, 1'b0);
    chk("heads", hsel, 1'b0);
    wr = 1'b0; rd = 1'b0;
    tag(3'h3, 8'h80);
    rd_byte(3'h4, 8'hff, 8'h88);
    tag(3'h3, 8'h40);
    rd_byte(3'h4, 8'hff, 8'h80);
    tag(3'h3, 8'h20); bwait();
    chk("heads", hsel, 1'b1);
    tag(3'h3, 8'h10);
    rd_byte(3'h4, 8'h80, 8'h00);
    pwr = 1'b1; cyc(1); pwr = 1'b0;
    rd_byte(3'h4, 8'hff, 8'h82);
    for (int i = 0; i < 2; i++) begin
      {msel, rd, wcd} = (i == 0) ? 3'b110 : 3'b001; cyc(2); {msel, rd, wcd} = 3'b000;
      rd_byte(3'h4, 8'h08, 8'h08);
      tag(3'h3, 8'h40);
      rd_byte(3'h4, 8'h08, 8'h00);
    end
    repeat (6) begin
      pes = 8'($urandom_range(40)); dr = 2'($urandom); cyc(3);
      rd_byte(3'h5, 8'had, s1_exp(pes, dr));
    end
    idx = 1'b1; cyc(1); idx = 1'b0;
    rd_byte(3'h5, 8'h20, 8'h00);
    // Two whole windows of a steady byte, then one bit toggling across a window
    cyc(520);
    rd_byte(3'h6, 8'hff, s2);
    chk("pulsing", pb, 8'h00);
    repeat (300) begin s2[0] = ~s2[0]; cyc(1); end
    rd_byte(3'h6, 8'hfe, s2 & 8'hfe);
    chk("pulsing", pb, 8'h01);
    chk("pulse parity", pp, 1'b0);
    vel = 1'b1; cyc(1); vel = 1'b0; cyc(2);
    rd_byte(3'h5, 8'h01, 8'h01);
    tag(3'h3, 8'h40);
    rd_byte(3'h5, 8'h01, 8'h00);
    for (int i = 0; i < 6; i++) begin
      flt = 6'(1 << i); cyc(3); flt = 6'h00;
      rd_byte(3'h4, 8'h05, 8'h05);
      tag(3'h3, 8'h80); bwait(); tag(3'h3, 8'h40);
      rd_byte(3'h4, 8'hff, 8'h82);
    end
    slow = 1'b1; tag(3'h3, 8'h80);
    rd_byte(3'h4, 8'h04, 8'h04);
    cyc(60);
    rd_byte(3'h4, 8'h01, 8'h01);
    slow = 1'b0; bwait(); tag(3'h3, 8'h80); bwait();
    rd_byte(3'h4, 8'h01, 8'h00);
    brk = 1'b1; cyc(55);
    chk("power down", pd, 1'b1);
    rd_byte(3'h4, 8'h40, 8'h40);
    wrap_up();
  end
endmodule
